// ==== verilog/tmr8_top.sv ====

`include "tmr8_defs.svh"

module tmr8_top (
    // clock, reset and freeze
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // prescaled timer tick, same clock domain
    input wire logic tmr_tick,
    // interrupt service acknowledges
    input wire logic ovf_serviced,
    input wire logic match_a_serviced,
    input wire logic match_b_serviced,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // waveform pins
    output logic wave_out_a,
    output logic wave_oe_a,
    output logic wave_out_b,
    output logic wave_oe_b,
    // flags for an interrupt controller
    output logic overflow_flag,
    output logic match_flag_a,
    output logic match_flag_b
);

    tmr8_pkg::tmr8_state_s st_r;
    tmr8_pkg::tmr8_state_s st_nxt;
    tmr8_pkg::tmr8_class_e cls;
    logic [7:0] top_val;
    logic tick_en;
    logic eq_a;
    logic eq_b;
    logic at_top;
    logic hit_a;
    logic hit_b;
    logic cnt_clear;
    logic bottom_evt;
    logic ovf_set;
    logic access;
    logic wr;
    logic cnt_wr;
    logic cmpa_wr;
    logic cmpb_wr;
    logic flags_wr;
    logic ovf_clr;
    logic mfa_clr;
    logic mfb_clr;

    tmr8_wave_if wa ();
    tmr8_wave_if wb ();

    ////////////////////////////////////////////////////////////////////////////
    // counting events

    assign cls = tmr8_pkg::tmr8_class(st_r.wsel);
    assign top_val = (cls == tmr8_pkg::TMR8_CLS_CTC || st_r.wsel == `TMR8_WSEL_FAST_OCR) ?
                     st_r.ocra : `TMR8_MAX;
    assign tick_en = tmr_tick && (st_r.css != `TMR8_CSS_STOP);
    assign eq_a = (st_r.cnt == st_r.ocra);
    assign eq_b = (st_r.cnt == st_r.ocrb);
    assign at_top = (st_r.cnt == top_val);
    // a count write blocks matches until the next tick has passed
    assign hit_a = tick_en && eq_a && !st_r.blk;
    assign hit_b = tick_en && eq_b && !st_r.blk;
    // ctc top clear follows the compare value directly, unbuffered
    assign cnt_clear = (cls == tmr8_pkg::TMR8_CLS_FAST) ? at_top :
                       (cls == tmr8_pkg::TMR8_CLS_CTC) ? eq_a : 1'b0;
    assign bottom_evt = tick_en && (cls == tmr8_pkg::TMR8_CLS_FAST) && at_top;
    assign ovf_set = tick_en && ((cls == tmr8_pkg::TMR8_CLS_FAST) ? at_top :
                     (st_r.cnt == `TMR8_MAX));

    ////////////////////////////////////////////////////////////////////////////
    // register bus decode

    assign access = psel && penable;
    assign wr = access && st_r.pready && pwrite;
    assign cnt_wr = wr && (paddr == `TMR8_ADDR_COUNT);
    assign cmpa_wr = wr && (paddr == `TMR8_ADDR_CMPA);
    assign cmpb_wr = wr && (paddr == `TMR8_ADDR_CMPB);
    assign flags_wr = wr && (paddr == `TMR8_ADDR_FLAGS);
    assign ovf_clr = (flags_wr && pwdata[`TMR8_FLAG_OVF]) || ovf_serviced;
    assign mfa_clr = (flags_wr && pwdata[`TMR8_FLAG_MFA]) || match_a_serviced;
    assign mfb_clr = (flags_wr && pwdata[`TMR8_FLAG_MFB]) || match_b_serviced;

    ////////////////////////////////////////////////////////////////////////////
    // waveform channels

    assign wa.nonpwm = (cls != tmr8_pkg::TMR8_CLS_FAST);
    assign wa.wsel_high = st_r.wsel[2];
    assign wa.act = tmr8_pkg::tmr8_act_e'(st_r.act_a);
    assign wa.match = hit_a;
    assign wa.bottom = bottom_evt;
    assign wa.ocr_is_top = (st_r.ocra == top_val);
    assign wa.force_hit = st_r.force_a;

    assign wb.nonpwm = (cls != tmr8_pkg::TMR8_CLS_FAST);
    assign wb.wsel_high = st_r.wsel[2];
    assign wb.act = tmr8_pkg::tmr8_act_e'(st_r.act_b);
    assign wb.match = hit_b;
    assign wb.bottom = bottom_evt;
    assign wb.ocr_is_top = (st_r.ocrb == top_val);
    assign wb.force_hit = st_r.force_b;

    tmr8_wave #(
        .TOGGLE_IN_PWM(1'b1)
    ) u_wave_a (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .wif(wa)
    );

    // channel b has no toggle in pwm
    tmr8_wave #(
        .TOGGLE_IN_PWM(1'b0)
    ) u_wave_b (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .wif(wb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.force_a = 1'b0;
        st_nxt.force_b = 1'b0;

        // two-cycle access: data is latched while pready is raised
        st_nxt.pready = access && !st_r.pready;
        if (access && !st_r.pready) begin
            st_nxt.pslverr = !tmr8_pkg::tmr8_mapped(paddr);
            st_nxt.prdata = `TMR8_RST_WORD;
            unique case (paddr)
                `TMR8_ADDR_CTRL: begin
                    st_nxt.prdata[`TMR8_CTRL_WSEL_LSB +: 3] = st_r.wsel;
                    st_nxt.prdata[`TMR8_CTRL_ACTA_LSB +: 2] = st_r.act_a;
                    st_nxt.prdata[`TMR8_CTRL_ACTB_LSB +: 2] = st_r.act_b;
                    st_nxt.prdata[`TMR8_CTRL_CSS_LSB +: 3] = st_r.css;
                end
                `TMR8_ADDR_COUNT: st_nxt.prdata[7:0] = st_r.cnt;
                `TMR8_ADDR_CMPA: st_nxt.prdata[7:0] = st_r.ocra_buf;
                `TMR8_ADDR_CMPB: st_nxt.prdata[7:0] = st_r.ocrb_buf;
                `TMR8_ADDR_FLAGS: begin
                    st_nxt.prdata[`TMR8_FLAG_OVF] = st_r.ovf;
                    st_nxt.prdata[`TMR8_FLAG_MFA] = st_r.mfa;
                    st_nxt.prdata[`TMR8_FLAG_MFB] = st_r.mfb;
                end
                `TMR8_ADDR_PINDIR: st_nxt.prdata[1:0] = st_r.dir;
                default: st_nxt.prdata = `TMR8_RST_WORD;
            endcase
        end

        // counter on the timer tick only
        if (tick_en) begin
            st_nxt.cnt = cnt_clear ? `TMR8_BOTTOM : 8'(st_r.cnt + 8'h01);
            st_nxt.blk = 1'b0;
            if (bottom_evt) begin
                st_nxt.ocra = st_r.ocra_buf;
                st_nxt.ocrb = st_r.ocrb_buf;
            end
        end

        // set beats clear on the same cycle
        st_nxt.ovf = (st_r.ovf && !ovf_clr) || ovf_set;
        st_nxt.mfa = (st_r.mfa && !mfa_clr) || hit_a;
        st_nxt.mfb = (st_r.mfb && !mfb_clr) || hit_b;

        if (wr) begin
            unique case (paddr)
                `TMR8_ADDR_CTRL: begin
                    st_nxt.wsel = pwdata[`TMR8_CTRL_WSEL_LSB +: 3];
                    st_nxt.act_a = pwdata[`TMR8_CTRL_ACTA_LSB +: 2];
                    st_nxt.act_b = pwdata[`TMR8_CTRL_ACTB_LSB +: 2];
                    st_nxt.css = pwdata[`TMR8_CTRL_CSS_LSB +: 3];
                end
                `TMR8_ADDR_COUNT: begin
                    st_nxt.cnt = pwdata[7:0];
                    st_nxt.blk = 1'b1;
                end
                `TMR8_ADDR_CMPA: begin
                    st_nxt.ocra_buf = pwdata[7:0];
                    // pwm waits for bottom; other modes take it at once
                    if (cls != tmr8_pkg::TMR8_CLS_FAST) begin
                        st_nxt.ocra = pwdata[7:0];
                    end
                end
                `TMR8_ADDR_CMPB: begin
                    st_nxt.ocrb_buf = pwdata[7:0];
                    if (cls != tmr8_pkg::TMR8_CLS_FAST) begin
                        st_nxt.ocrb = pwdata[7:0];
                    end
                end
                `TMR8_ADDR_FORCE: begin
                    st_nxt.force_a = pwdata[`TMR8_CH_A];
                    st_nxt.force_b = pwdata[`TMR8_CH_B];
                end
                `TMR8_ADDR_PINDIR: st_nxt.dir = pwdata[1:0];
                default: st_nxt.dir = st_r.dir;
            endcase
        end

        // pin follows the wave bit only when connected; direction drives only the oe outputs
        st_nxt.pin_a = (st_r.act_a != tmr8_pkg::TMR8_ACT_OFF) && wa.wave;
        st_nxt.pin_b = (st_r.act_b != tmr8_pkg::TMR8_ACT_OFF) && wb.wave;
        st_nxt.oe_a = st_r.dir[`TMR8_CH_A];
        st_nxt.oe_b = st_r.dir[`TMR8_CH_B];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign pready = st_r.pready;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr;
    assign wave_out_a = st_r.pin_a;
    assign wave_oe_a = st_r.oe_a;
    assign wave_out_b = st_r.pin_b;
    assign wave_oe_b = st_r.oe_b;
    assign overflow_flag = st_r.ovf;
    assign match_flag_a = st_r.mfa;
    assign match_flag_b = st_r.mfb;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_run;
        ce && tick_en && !cnt_wr;
    endsequence

    sequence s_normal_run;
        s_run ##0 (cls == tmr8_pkg::TMR8_CLS_NORMAL);
    endsequence

    sequence s_ctc_top;
        s_run ##0 (cls == tmr8_pkg::TMR8_CLS_CTC) && eq_a;
    endsequence

    sequence s_fast_top;
        s_run ##0 (cls == tmr8_pkg::TMR8_CLS_FAST) && at_top;
    endsequence

    AST_NORMAL_INC: assert property (s_normal_run |=> st_r.cnt == 8'($past(st_r.cnt) + 8'h01))
        else $error("normal mode did not increment");

    AST_NORMAL_WRAP: assert property (s_normal_run ##0 st_r.cnt == `TMR8_MAX |=>
        st_r.cnt == `TMR8_BOTTOM && st_r.ovf)
        else $error("normal wrap missed zero or overflow flag");

    AST_CTC_CLEAR: assert property (s_ctc_top |=> st_r.cnt == `TMR8_BOTTOM)
        else $error("ctc did not clear on match");

    AST_CTC_FLAG: assert property (s_ctc_top ##0 !st_r.blk |=> st_r.mfa)
        else $error("ctc match did not set flag a");

    AST_FAST_TOP: assert property (s_fast_top |=> st_r.cnt == `TMR8_BOTTOM && st_r.ovf)
        else $error("fast pwm top did not clear count and set overflow");

    AST_STOPPED: assert property (ce && st_r.css == `TMR8_CSS_STOP && !cnt_wr |=>
        st_r.cnt == $past(st_r.cnt))
        else $error("stopped timer changed its count");

    AST_BLOCKED: assert property (ce && st_r.blk && eq_b && !st_r.mfb && !match_b_serviced |=>
        !st_r.mfb)
        else $error("blocked match set flag b");

    AST_W1C: assert property (ce && flags_wr && pwdata[`TMR8_FLAG_MFA] && !hit_a |=> !st_r.mfa)
        else $error("writing one did not clear flag a");

    AST_BUFFERED: assert property (ce && cmpa_wr && cls == tmr8_pkg::TMR8_CLS_FAST && !bottom_evt |=>
        st_r.ocra == $past(st_r.ocra))
        else $error("pwm compare write bypassed the buffer");

    AST_PIN_DIR: assert property (ce && !st_r.dir[`TMR8_CH_A] |=> !wave_oe_a)
        else $error("pin a driven while direction is input");

    AST_FREEZE: assert property (!ce |=>
        st_r == $past(st_r))
        else $error("state moved while clock enable was low");

    AST_CTC_OVF: assert property (s_run ##0 cls == tmr8_pkg::TMR8_CLS_CTC && st_r.cnt == `TMR8_MAX |=>
        st_r.ovf)
        else $error("ctc pass through max did not set overflow");

    AST_FAST_OCR_TOP: assert property (s_run ##0 st_r.wsel == `TMR8_WSEL_FAST_OCR && eq_a |=>
        st_r.cnt == `TMR8_BOTTOM)
        else $error("fast pwm with compare top did not restart");

    AST_FORCE_NO_FLAG: assert property (ce && st_r.force_a && !hit_a && !st_r.mfa |=>
        !st_r.mfa)
        else $error("force strobe set match flag a");

    AST_OVF_SET_WINS: assert property (ce && ovf_set && ovf_clr |=>
        st_r.ovf)
        else $error("overflow clear beat a same-cycle set");

    AST_B_NO_TOGGLE: assert property (ce && !wb.nonpwm && wb.match && wb.act == tmr8_pkg::TMR8_ACT_TOGGLE |=>
        wb.wave == $past(wb.wave))
        else $error("channel b toggled in pwm");

endmodule : tmr8_top

// ==== verilog/tmr8_defs.svh ====
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

// register byte offsets
`define TMR8_ADDR_CTRL 8'h00
`define TMR8_ADDR_COUNT 8'h04
`define TMR8_ADDR_CMPA 8'h08
`define TMR8_ADDR_CMPB 8'h0C
`define TMR8_ADDR_FLAGS 8'h10
`define TMR8_ADDR_FORCE 8'h14
`define TMR8_ADDR_PINDIR 8'h18

// control field positions
`define TMR8_CTRL_WSEL_LSB 0
`define TMR8_CTRL_ACTA_LSB 4
`define TMR8_CTRL_ACTB_LSB 6
`define TMR8_CTRL_CSS_LSB 8

// flag, force and direction bit positions
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_MFA 1
`define TMR8_FLAG_MFB 2
`define TMR8_CH_A 0
`define TMR8_CH_B 1

// count extremes and mode codes
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hFF
`define TMR8_WSEL_CTC 3'h2
`define TMR8_WSEL_FAST 3'h3
`define TMR8_WSEL_FAST_OCR 3'h7
`define TMR8_CSS_STOP 3'h0

// reset values
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_WORD 32'h0000_0000

`endif

// ==== verilog/tmr8_pkg.sv ====
`include "tmr8_defs.svh"

package tmr8_pkg;

    typedef enum logic [1:0] {
        TMR8_CLS_NORMAL = 2'b00,
        TMR8_CLS_CTC = 2'b01,
        TMR8_CLS_FAST = 2'b10
    } tmr8_class_e;

    typedef enum logic [1:0] {
        TMR8_ACT_OFF = 2'b00,
        TMR8_ACT_TOGGLE = 2'b01,
        TMR8_ACT_CLEAR = 2'b10,
        TMR8_ACT_SET = 2'b11
    } tmr8_act_e;

    typedef struct packed {
        logic [2:0] wsel;
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [2:0] css;
        logic [7:0] cnt;
        logic [7:0] ocra;
        logic [7:0] ocrb;
        logic [7:0] ocra_buf;
        logic [7:0] ocrb_buf;
        logic ovf;
        logic mfa;
        logic mfb;
        logic blk;
        logic [1:0] dir;
        logic force_a;
        logic force_b;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic pin_a;
        logic pin_b;
        logic oe_a;
        logic oe_b;
    } tmr8_state_s;

    typedef struct packed {
        logic wave;
    } tmr8_wave_s;

    // modes outside the three supported ones run as normal counting
    function automatic tmr8_class_e tmr8_class(input logic [2:0] wsel);
        unique case (wsel)
            `TMR8_WSEL_CTC: tmr8_class = TMR8_CLS_CTC;
            `TMR8_WSEL_FAST, `TMR8_WSEL_FAST_OCR: tmr8_class = TMR8_CLS_FAST;
            default: tmr8_class = TMR8_CLS_NORMAL;
        endcase
    endfunction : tmr8_class

    function automatic logic tmr8_mapped(input logic [7:0] addr);
        tmr8_mapped = (addr == `TMR8_ADDR_CTRL) || (addr == `TMR8_ADDR_COUNT) ||
                      (addr == `TMR8_ADDR_CMPA) || (addr == `TMR8_ADDR_CMPB) ||
                      (addr == `TMR8_ADDR_FLAGS) || (addr == `TMR8_ADDR_FORCE) ||
                      (addr == `TMR8_ADDR_PINDIR);
    endfunction : tmr8_mapped

endpackage : tmr8_pkg

// ==== verilog/tmr8_wave_if.sv ====
interface tmr8_wave_if;
    logic nonpwm;
    logic wsel_high;
    tmr8_pkg::tmr8_act_e act;
    logic match;
    logic bottom;
    logic ocr_is_top;
    logic force_hit;
    logic wave;

    modport ctl (
        output nonpwm, wsel_high, act, match, bottom, ocr_is_top, force_hit,
        input wave
    );
    modport ch (
        input nonpwm, wsel_high, act, match, bottom, ocr_is_top, force_hit,
        output wave
    );
endinterface : tmr8_wave_if

// ==== verilog/tmr8_wave.sv ====
module tmr8_wave #(
    parameter bit TOGGLE_IN_PWM = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // compare events and waveform bit
    tmr8_wave_if.ch wif
);

    tmr8_pkg::tmr8_wave_s st_r;
    tmr8_pkg::tmr8_wave_s st_nxt;

    assign wif.wave = st_r.wave;

    always_comb begin
        st_nxt = st_r;
        if (wif.nonpwm) begin
            // new action is only consulted at a match or force strobe, so a change waits for one
            if (wif.match || wif.force_hit) begin
                unique case (wif.act)
                    tmr8_pkg::TMR8_ACT_OFF: st_nxt.wave = st_r.wave;
                    tmr8_pkg::TMR8_ACT_TOGGLE: st_nxt.wave = ~st_r.wave;
                    tmr8_pkg::TMR8_ACT_CLEAR: st_nxt.wave = 1'b0;
                    tmr8_pkg::TMR8_ACT_SET: st_nxt.wave = 1'b1;
                endcase
            end
        end else begin
            // match at top with a pwm action is ignored; top handles it
            if (wif.match && !(wif.ocr_is_top && wif.act[1])) begin
                unique case (wif.act)
                    tmr8_pkg::TMR8_ACT_OFF: st_nxt.wave = st_r.wave;
                    tmr8_pkg::TMR8_ACT_TOGGLE: st_nxt.wave = (TOGGLE_IN_PWM && wif.wsel_high) ? ~st_r.wave : st_r.wave;
                    tmr8_pkg::TMR8_ACT_CLEAR: st_nxt.wave = 1'b0;
                    tmr8_pkg::TMR8_ACT_SET: st_nxt.wave = 1'b1;
                endcase
            end
            if (wif.bottom) begin
                if (wif.act == tmr8_pkg::TMR8_ACT_CLEAR) begin
                    st_nxt.wave = 1'b1;
                end else if (wif.act == tmr8_pkg::TMR8_ACT_SET) begin
                    st_nxt.wave = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    AST_FORCE_TOGGLE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && wif.nonpwm && wif.force_hit && wif.act == tmr8_pkg::TMR8_ACT_TOGGLE |=> wif.wave != $past(wif.wave))
        else $error("force strobe did not toggle the wave bit");

    AST_PWM_BOTTOM_SET: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !wif.nonpwm && wif.bottom && wif.act == tmr8_pkg::TMR8_ACT_CLEAR |=> wif.wave)
        else $error("non-inverting pwm did not set at bottom");

endmodule : tmr8_wave

// ==== sim/testbench.sv ====
`include "tmr8_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, ce, tmr_tick, ovf_serviced, match_a_serviced, match_b_serviced;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic wave_out_a, wave_oe_a, wave_out_b, wave_oe_b, overflow_flag, match_flag_a, match_flag_b;
    int fails, tests_run;

    tmr8_top DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .tmr_tick(tmr_tick), .ovf_serviced(ovf_serviced),
        .match_a_serviced(match_a_serviced), .match_b_serviced(match_b_serviced), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a),
        .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b), .overflow_flag(overflow_flag),
        .match_flag_a(match_flag_a), .match_flag_b(match_flag_b));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk

    // one apb transfer; the slave's latency is waited for, never assumed
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask : apb

    task wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask : wr

    task rdchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk

    // back-to-back timer ticks, one per sys_clk
    task ticks(input int n);
        tmr_tick <= 1'b1;
        repeat (n) @(posedge sys_clk);
        tmr_tick <= 1'b0;
    endtask : ticks

    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdchk("ctrl", `TMR8_ADDR_CTRL, 32'h0000_0000);
        rdchk("count", `TMR8_ADDR_COUNT, 32'h0000_0000);
        rdchk("flags", `TMR8_ADDR_FLAGS, 32'h0000_0000);
        chk("wave a", 32'h0000_0000, {31'h0, wave_out_a});
        chk("wave b", 32'h0000_0000, {31'h0, wave_out_b});
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
    endtask : t_reset

    task t_normal;
        wr(`TMR8_ADDR_CTRL, 32'h0000_0100);
        wr(`TMR8_ADDR_COUNT, 32'h0000_00FE);
        ticks(2);
        rdchk("wrap count", `TMR8_ADDR_COUNT, 32'h0000_0000);
        rdchk("ovf set", `TMR8_ADDR_FLAGS, 32'h0000_0001);
        chk("ovf out", 32'h0000_0001, {31'h0, overflow_flag});
        repeat (5) @(posedge sys_clk);
        rdchk("no tick hold", `TMR8_ADDR_COUNT, 32'h0000_0000);
        ce <= 1'b0;
        ticks(3);
        ce <= 1'b1;
        rdchk("frozen", `TMR8_ADDR_COUNT, 32'h0000_0000);
        // both compares sit at zero, so the first tick from zero matches them
        ticks(3);
        rdchk("count up", `TMR8_ADDR_COUNT, 32'h0000_0003);
        rdchk("ovf kept", `TMR8_ADDR_FLAGS, 32'h0000_0007);
        ovf_serviced <= 1'b1;
        @(posedge sys_clk);
        ovf_serviced <= 1'b0;
        rdchk("ovf serviced", `TMR8_ADDR_FLAGS, 32'h0000_0006);
        wr(`TMR8_ADDR_FLAGS, 32'h0000_0006);
        wr(`TMR8_ADDR_CTRL, 32'h0000_0000);
        ticks(2);
        rdchk("stopped", `TMR8_ADDR_COUNT, 32'h0000_0003);
        wr(`TMR8_ADDR_COUNT, 32'h0000_0040);
        rdchk("stopped write", `TMR8_ADDR_COUNT, 32'h0000_0040);
    endtask : t_normal

    task t_block;
        wr(`TMR8_ADDR_CTRL, 32'h0000_0100);
        wr(`TMR8_ADDR_CMPB, 32'h0000_0005);
        wr(`TMR8_ADDR_COUNT, 32'h0000_0005);
        ticks(1);
        rdchk("blocked match", `TMR8_ADDR_FLAGS, 32'h0000_0000);
        wr(`TMR8_ADDR_COUNT, 32'h0000_0004);
        ticks(2);
        rdchk("match b", `TMR8_ADDR_FLAGS, 32'h0000_0004);
        chk("flag b out", 32'h0000_0001, {31'h0, match_flag_b});
        wr(`TMR8_ADDR_FLAGS, 32'h0000_0004);
        rdchk("w1c b", `TMR8_ADDR_FLAGS, 32'h0000_0000);
    endtask : t_block

    task t_force;
        wr(`TMR8_ADDR_PINDIR, 32'h0000_0003);
        wr(`TMR8_ADDR_CTRL, 32'h0000_00C0);
        wr(`TMR8_ADDR_FORCE, 32'h0000_0002);
        repeat (4) @(posedge sys_clk);
        chk("forced b", 32'h0000_0001, {31'h0, wave_out_b});
        chk("oe b", 32'h0000_0001, {31'h0, wave_oe_b});
        chk("oe a", 32'h0000_0001, {31'h0, wave_oe_a});
        rdchk("force no flag", `TMR8_ADDR_FLAGS, 32'h0000_0000);
        // mid-run reset must drop the internal wave bit, not just the pin
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        wr(`TMR8_ADDR_CTRL, 32'h0000_00C0);
        repeat (2) @(posedge sys_clk);
        chk("reset wave b", 32'h0000_0000, {31'h0, wave_out_b});
    endtask : t_force

    task t_ctc;
        wr(`TMR8_ADDR_CTRL, 32'h0000_0112);
        wr(`TMR8_ADDR_CMPA, 32'h0000_0003);
        wr(`TMR8_ADDR_COUNT, 32'h0000_0000);
        ticks(4);
        rdchk("ctc clear", `TMR8_ADDR_COUNT, 32'h0000_0000);
        rdchk("ctc flag a", `TMR8_ADDR_FLAGS, 32'h0000_0002);
        chk("flag a out", 32'h0000_0001, {31'h0, match_flag_a});
        chk("ctc toggle", 32'h0000_0001, {31'h0, wave_out_a});
        wr(`TMR8_ADDR_FLAGS, 32'h0000_0002);
    endtask : t_ctc

    // top 0xFF, compare 2: set at bottom, clear on match, 256-tick period
    task t_fast;
        wr(`TMR8_ADDR_CTRL, 32'h0000_0000);
        wr(`TMR8_ADDR_CMPA, 32'h0000_0002);
        wr(`TMR8_ADDR_COUNT, 32'h0000_00FE);
        wr(`TMR8_ADDR_CTRL, 32'h0000_0123);
        ticks(2);
        rdchk("fast ovf", `TMR8_ADDR_FLAGS, 32'h0000_0001);
        chk("set bottom", 32'h0000_0001, {31'h0, wave_out_a});
        ticks(3);
        rdchk("fast count", `TMR8_ADDR_COUNT, 32'h0000_0003);
        chk("clear match", 32'h0000_0000, {31'h0, wave_out_a});
        ticks(253);
        rdchk("period", `TMR8_ADDR_COUNT, 32'h0000_0000);
        chk("set again", 32'h0000_0001, {31'h0, wave_out_a});
        wr(`TMR8_ADDR_CTRL, 32'h0000_0133);
        ticks(256);
        rdchk("inv count", `TMR8_ADDR_COUNT, 32'h0000_0000);
        chk("inv bottom", 32'h0000_0000, {31'h0, wave_out_a});
        ticks(3);
        rdchk("inv count 3", `TMR8_ADDR_COUNT, 32'h0000_0003);
        chk("inv match", 32'h0000_0001, {31'h0, wave_out_a});
    endtask : t_fast

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        tests_run = 0;
        rst = 1'b1;
        ce = 1'b1;
        tmr_tick = 1'b0;
        ovf_serviced = 1'b0;
        match_a_serviced = 1'b0;
        match_b_serviced = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_normal();
        t_block();
        t_force();
        t_ctc();
        t_fast();
        give_verdict();
    end
endmodule : testbench
